// [core/bbou_pkg.sv]
package bbou_pkg;

  // ------------------------------------------------------------
  // Widths.
  // ------------------------------------------------------------
  localparam int unsigned PC_W   = 12;
  localparam int unsigned ADDR_W = 8;

  // ------------------------------------------------------------
  // Status flag bit positions.
  // ------------------------------------------------------------
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ------------------------------------------------------------
  // Register offsets, fields and reset values.
  // ------------------------------------------------------------
  localparam logic [7:0]  OFS_FLAGS   = 8'h00;
  localparam logic [7:0]  OFS_CTRL    = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_RETIRED = 8'h0C;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_TAKEN_BIT  = 1;
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic        ENABLE_RESET  = 1'h1;
  localparam logic [15:0] RETIRED_RESET = 16'h0000;

  // ------------------------------------------------------------
  // Cycle costs.
  // ------------------------------------------------------------
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  typedef enum logic [5:0] {
    OP_NOP,
    OP_BRANCH_FLAG_CLEAR, OP_BRANCH_IF_EQUAL, OP_BRANCH_IF_NOT_EQUAL,
    OP_BRANCH_CARRY_ONE, OP_BRANCH_CARRY_ZERO, OP_BRANCH_UNSIGNED_GE,
    OP_BRANCH_UNSIGNED_LT, OP_BRANCH_NEGATIVE, OP_BRANCH_POSITIVE,
    OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT, OP_BRANCH_HALFCARRY_ONE,
    OP_BRANCH_HALFCARRY_ZERO, OP_BRANCH_TFLAG_ONE, OP_BRANCH_TFLAG_ZERO,
    OP_BRANCH_OVERFLOW_ONE, OP_BRANCH_OVERFLOW_ZERO, OP_BRANCH_IRQ_ENABLED,
    OP_BRANCH_IRQ_DISABLED,
    OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_LOGICAL_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT, OP_NIBBLE_SWAP,
    OP_INDEXED_FLAG_SET, OP_INDEXED_FLAG_CLEAR, OP_STORE_BIT_TO_T,
    OP_LOAD_BIT_FROM_T,
    OP_SET_CARRY_FLAG, OP_CLEAR_CARRY_FLAG, OP_SET_NEGATIVE_FLAG,
    OP_CLEAR_NEGATIVE_FLAG, OP_SET_ZERO_FLAG, OP_CLEAR_ZERO_FLAG,
    OP_GLOBAL_IRQ_ENABLE, OP_GLOBAL_IRQ_DISABLE, OP_SET_SIGN_FLAG,
    OP_CLEAR_SIGN_FLAG, OP_SET_OVERFLOW_FLAG, OP_CLEAR_OVERFLOW_FLAG,
    OP_SET_T_FLAG, OP_CLEAR_T_FLAG
  } bbou_op_type;

  typedef struct packed {
    logic            valid;
    bbou_op_type     op;
    logic [4:0]      rd_addr;
    logic [7:0]      rd_val;
    logic [7:0]      rr_val;
    logic [2:0]      bit_sel;
    logic [4:0]      io_addr;
    logic [6:0]      offset;
    logic [PC_W-1:0] pc;
  } bbou_instr_type;

  typedef struct packed {
    logic            done;
    logic            pc_load;
    logic [PC_W-1:0] pc_value;
    logic            rd_we;
    logic [4:0]      rd_addr;
    logic [7:0]      rd_data;
    logic            io_we;
    logic [4:0]      io_addr;
    logic [2:0]      io_bit;
    logic            io_val;
  } bbou_result_type;

endpackage

// [core/bbou_unit.sv]
// Operation
// - Flag-clear branch jumps to pc+k+1 when flag s is zero; one or two cycles.
// - Carry-set/lower branch on C one; carry-clear/same-or-higher on C zero.
// - Signed greater-or-equal branch taken when N xor V is zero.
// - Signed less-than branch taken when N xor V is one; one or two cycles.
// - Half-carry branches taken on H one or H zero.
// - T branches taken on T one or T zero.
// - Overflow branches taken on V one or V zero.
// - Interrupt-enabled branch on I one, interrupt-disabled branch on I zero.
// - I/O bit set and clear force bit b of port P; two cycles, no flags.
// - Rotate left through carry; updates Z, C, N, V in one cycle.
// - Rotate right through carry; updates Z, C, N, V in one cycle.
// - Arithmetic shift right keeps bit 7; updates Z, C, N, V in one cycle.
// - Bit store copies Rr bit b into T, changing only T.
// - Bit load copies T into Rd bit b, flags unchanged.
// - Global interrupt enable and disable set or clear I in one cycle.
// - Overflow set and clear force V only, in one cycle.
// - Sign set and clear force S, in one cycle.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module bbou_unit (
  // Clock and reset.
  input  wire logic                     CLK,
  input  wire logic                     RST_N,
  // APB slave.
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [bbou_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  // Instruction from decode.
  input  wire bbou_pkg::bbou_instr_type INSTR,
  output logic                          INSTR_READY,
  // Results to core.
  output bbou_pkg::bbou_result_type     RESULT,
  output logic      [7:0]               FLAGS
);

  typedef struct packed {
    logic [7:0]                flags;
    logic                      enable;
    logic                      stall;
    logic                      ready;
    logic                      last_taken;
    logic [15:0]               retired;
    bbou_pkg::bbou_result_type res;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
  } bbou_state_type;

  bbou_state_type st_r;
  bbou_state_type st_nxt;

  logic                      accept;
  logic                      take;
  logic                      shift_op;
  logic [7:0]                sh_val;
  logic                      sh_carry;
  logic [bbou_pkg::PC_W-1:0] target;
  logic [1:0]                cost;

  assign accept = INSTR.valid && st_r.ready;
  assign target = bbou_pkg::PC_W'(INSTR.pc + {{5{INSTR.offset[6]}}, INSTR.offset}
                                  + bbou_pkg::PC_W'(1));

  // ------------------------------------------------------------
  // Branch condition.
  // ------------------------------------------------------------
  always_comb begin
    take = 1'b0;
    unique case (INSTR.op)
      bbou_pkg::OP_BRANCH_FLAG_CLEAR: take = !st_r.flags[INSTR.bit_sel];
      bbou_pkg::OP_BRANCH_IF_EQUAL: begin
        take = st_r.flags[bbou_pkg::FLAG_Z];
      end
      bbou_pkg::OP_BRANCH_IF_NOT_EQUAL: begin
        take = !st_r.flags[bbou_pkg::FLAG_Z];
      end
      bbou_pkg::OP_BRANCH_CARRY_ONE,
      bbou_pkg::OP_BRANCH_UNSIGNED_LT: take = st_r.flags[bbou_pkg::FLAG_C];
      bbou_pkg::OP_BRANCH_CARRY_ZERO,
      bbou_pkg::OP_BRANCH_UNSIGNED_GE: take = !st_r.flags[bbou_pkg::FLAG_C];
      bbou_pkg::OP_BRANCH_NEGATIVE: begin
        take = st_r.flags[bbou_pkg::FLAG_N];
      end
      bbou_pkg::OP_BRANCH_POSITIVE: begin
        take = !st_r.flags[bbou_pkg::FLAG_N];
      end
      bbou_pkg::OP_BRANCH_SIGNED_GE: take = !(st_r.flags[bbou_pkg::FLAG_N]
                                              ^ st_r.flags[bbou_pkg::FLAG_V]);
      bbou_pkg::OP_BRANCH_SIGNED_LT: take = st_r.flags[bbou_pkg::FLAG_N]
                                            ^ st_r.flags[bbou_pkg::FLAG_V];
      bbou_pkg::OP_BRANCH_HALFCARRY_ONE: begin
        take = st_r.flags[bbou_pkg::FLAG_H];
      end
      bbou_pkg::OP_BRANCH_HALFCARRY_ZERO: begin
        take = !st_r.flags[bbou_pkg::FLAG_H];
      end
      bbou_pkg::OP_BRANCH_TFLAG_ONE: begin
        take = st_r.flags[bbou_pkg::FLAG_T];
      end
      bbou_pkg::OP_BRANCH_TFLAG_ZERO: begin
        take = !st_r.flags[bbou_pkg::FLAG_T];
      end
      bbou_pkg::OP_BRANCH_OVERFLOW_ONE: begin
        take = st_r.flags[bbou_pkg::FLAG_V];
      end
      bbou_pkg::OP_BRANCH_OVERFLOW_ZERO: begin
        take = !st_r.flags[bbou_pkg::FLAG_V];
      end
      bbou_pkg::OP_BRANCH_IRQ_ENABLED: begin
        take = st_r.flags[bbou_pkg::FLAG_I];
      end
      bbou_pkg::OP_BRANCH_IRQ_DISABLED: begin
        take = !st_r.flags[bbou_pkg::FLAG_I];
      end
      default: take = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Shifter.
  // ------------------------------------------------------------
  always_comb begin
    shift_op = 1'b1;
    sh_val   = INSTR.rd_val;
    sh_carry = st_r.flags[bbou_pkg::FLAG_C];
    unique case (INSTR.op)
      bbou_pkg::OP_LOGICAL_SHIFT_LEFT: begin
        sh_val   = {INSTR.rd_val[6:0], 1'b0};
        sh_carry = INSTR.rd_val[7];
      end
      bbou_pkg::OP_LOGICAL_SHIFT_RIGHT: begin
        sh_val   = {1'b0, INSTR.rd_val[7:1]};
        sh_carry = INSTR.rd_val[0];
      end
      bbou_pkg::OP_ROTATE_LEFT_CARRY: begin
        sh_val   = {INSTR.rd_val[6:0], st_r.flags[bbou_pkg::FLAG_C]};
        sh_carry = INSTR.rd_val[7];
      end
      bbou_pkg::OP_ROTATE_RIGHT_CARRY: begin
        sh_val   = {st_r.flags[bbou_pkg::FLAG_C], INSTR.rd_val[7:1]};
        sh_carry = INSTR.rd_val[0];
      end
      bbou_pkg::OP_ARITH_SHIFT_RIGHT: begin
        sh_val   = {INSTR.rd_val[7], INSTR.rd_val[7:1]};
        sh_carry = INSTR.rd_val[0];
      end
      default: shift_op = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Next state.
  // ------------------------------------------------------------
  always_comb begin
    st_nxt         = st_r;
    st_nxt.res     = '0;
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;
    cost           = bbou_pkg::CYC_ONE;

    // APB access: one wait state, then write or read completes.
    if (PSEL && PENABLE && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = '0;
      unique case (PADDR)
        bbou_pkg::OFS_FLAGS:   st_nxt.prdata[7:0] = st_r.flags;
        bbou_pkg::OFS_CTRL:    st_nxt.prdata[bbou_pkg::CTRL_ENABLE_BIT] = st_r.enable;
        bbou_pkg::OFS_STATUS: begin
          st_nxt.prdata[bbou_pkg::STAT_BUSY_BIT]  = st_r.stall;
          st_nxt.prdata[bbou_pkg::STAT_TAKEN_BIT] = st_r.last_taken;
        end
        bbou_pkg::OFS_RETIRED: st_nxt.prdata[15:0] = st_r.retired;
        default:               st_nxt.pslverr = 1'b1;
      endcase
    end
    if (PSEL && PENABLE && st_r.pready && PWRITE) begin
      if (PADDR == bbou_pkg::OFS_FLAGS) begin
        st_nxt.flags = PWDATA[7:0];
      end
      if (PADDR == bbou_pkg::OFS_CTRL) begin
        st_nxt.enable = PWDATA[bbou_pkg::CTRL_ENABLE_BIT];
      end
    end

    // Instruction execution; any accepted instruction discards a same-cycle bus write to the flags.
    if (accept) begin
      st_nxt.res.done = 1'b1;
      st_nxt.retired  = st_r.retired + 16'h0001;
      st_nxt.flags    = st_r.flags;
      if (INSTR.op >= bbou_pkg::OP_BRANCH_FLAG_CLEAR
          && INSTR.op <= bbou_pkg::OP_BRANCH_IRQ_DISABLED) begin
        st_nxt.last_taken = take;
        if (take) begin
          st_nxt.res.pc_load  = 1'b1;
          st_nxt.res.pc_value = target;
          cost                = bbou_pkg::CYC_TWO;
        end
      end
      if (shift_op) begin
        st_nxt.res.rd_we                = 1'b1;
        st_nxt.res.rd_addr              = INSTR.rd_addr;
        st_nxt.res.rd_data              = sh_val;
        st_nxt.flags[bbou_pkg::FLAG_Z]  = (sh_val == 8'h00);
        st_nxt.flags[bbou_pkg::FLAG_C]  = sh_carry;
        st_nxt.flags[bbou_pkg::FLAG_N]  = sh_val[7];
        st_nxt.flags[bbou_pkg::FLAG_V]  = sh_val[7] ^ sh_carry;
      end
      unique case (INSTR.op)
        bbou_pkg::OP_IO_BIT_SET,
        bbou_pkg::OP_IO_BIT_CLEAR: begin
          st_nxt.res.io_we   = 1'b1;
          st_nxt.res.io_addr = INSTR.io_addr;
          st_nxt.res.io_bit  = INSTR.bit_sel;
          st_nxt.res.io_val  = (INSTR.op == bbou_pkg::OP_IO_BIT_SET);
          cost               = bbou_pkg::CYC_TWO;
        end
        bbou_pkg::OP_NIBBLE_SWAP: begin
          st_nxt.res.rd_we   = 1'b1;
          st_nxt.res.rd_addr = INSTR.rd_addr;
          st_nxt.res.rd_data = {INSTR.rd_val[3:0], INSTR.rd_val[7:4]};
        end
        bbou_pkg::OP_INDEXED_FLAG_SET: begin
          st_nxt.flags[INSTR.bit_sel] = 1'b1;
        end
        bbou_pkg::OP_INDEXED_FLAG_CLEAR: begin
          st_nxt.flags[INSTR.bit_sel] = 1'b0;
        end
        bbou_pkg::OP_STORE_BIT_TO_T: begin
          st_nxt.flags[bbou_pkg::FLAG_T] = INSTR.rr_val[INSTR.bit_sel];
        end
        bbou_pkg::OP_LOAD_BIT_FROM_T: begin
          st_nxt.res.rd_we                  = 1'b1;
          st_nxt.res.rd_addr                = INSTR.rd_addr;
          st_nxt.res.rd_data                = INSTR.rd_val;
          st_nxt.res.rd_data[INSTR.bit_sel] = st_r.flags[bbou_pkg::FLAG_T];
        end
        bbou_pkg::OP_SET_CARRY_FLAG: begin
          st_nxt.flags[bbou_pkg::FLAG_C] = 1'b1;
        end
        bbou_pkg::OP_CLEAR_CARRY_FLAG: begin
          st_nxt.flags[bbou_pkg::FLAG_C] = 1'b0;
        end
        bbou_pkg::OP_SET_NEGATIVE_FLAG: begin
          st_nxt.flags[bbou_pkg::FLAG_N] = 1'b1;
        end
        bbou_pkg::OP_CLEAR_NEGATIVE_FLAG: begin
          st_nxt.flags[bbou_pkg::FLAG_N] = 1'b0;
        end
        bbou_pkg::OP_SET_ZERO_FLAG: begin
          st_nxt.flags[bbou_pkg::FLAG_Z] = 1'b1;
        end
        bbou_pkg::OP_CLEAR_ZERO_FLAG: begin
          st_nxt.flags[bbou_pkg::FLAG_Z] = 1'b0;
        end
        bbou_pkg::OP_SET_T_FLAG: begin
          st_nxt.flags[bbou_pkg::FLAG_T] = 1'b1;
        end
        bbou_pkg::OP_CLEAR_T_FLAG: begin
          st_nxt.flags[bbou_pkg::FLAG_T] = 1'b0;
        end
        bbou_pkg::OP_GLOBAL_IRQ_ENABLE: begin
          st_nxt.flags[bbou_pkg::FLAG_I] = 1'b1;
        end
        bbou_pkg::OP_GLOBAL_IRQ_DISABLE: begin
          st_nxt.flags[bbou_pkg::FLAG_I] = 1'b0;
        end
        bbou_pkg::OP_SET_SIGN_FLAG: begin
          st_nxt.flags[bbou_pkg::FLAG_S] = 1'b1;
        end
        bbou_pkg::OP_CLEAR_SIGN_FLAG: begin
          st_nxt.flags[bbou_pkg::FLAG_S] = 1'b0;
        end
        bbou_pkg::OP_SET_OVERFLOW_FLAG: begin
          st_nxt.flags[bbou_pkg::FLAG_V] = 1'b1;
        end
        bbou_pkg::OP_CLEAR_OVERFLOW_FLAG: begin
          st_nxt.flags[bbou_pkg::FLAG_V] = 1'b0;
        end
        default: ;
      endcase
    end

    // two-cycle ops stall one extra cycle.
    st_nxt.stall = accept && (cost == bbou_pkg::CYC_TWO);
    st_nxt.ready = st_nxt.enable && !st_nxt.stall;
  end

  // ------------------------------------------------------------
  // State register.
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r            <= '0;
      st_r.flags      <= bbou_pkg::FLAGS_RESET;
      st_r.enable     <= bbou_pkg::ENABLE_RESET;
      st_r.ready      <= bbou_pkg::ENABLE_RESET;
      st_r.retired    <= bbou_pkg::RETIRED_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA      = st_r.prdata;
  assign PREADY      = st_r.pready;
  assign PSLVERR     = st_r.pslverr;
  assign INSTR_READY = st_r.ready;
  assign RESULT      = st_r.res;
  assign FLAGS       = st_r.flags;

endmodule

`default_nettype wire

// [verif/bbou_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker.
// ----------------------------------------------------------------
module bbou_sva (
  // Clock and reset.
  input wire logic                      CLK,
  input wire logic                      RST_N,
  // APB.
  input wire logic                      PSEL,
  input wire logic                      PENABLE,
  input wire logic                      PWRITE,
  input wire logic [7:0]                PADDR,
  input wire logic [31:0]               PWDATA,
  input wire logic [31:0]               PRDATA,
  input wire logic                      PREADY,
  input wire logic                      PSLVERR,
  // Core side.
  input wire bbou_pkg::bbou_instr_type  INSTR,
  input wire logic                      INSTR_READY,
  input wire bbou_pkg::bbou_result_type RESULT,
  input wire logic [7:0]                FLAGS
);
  logic        take;
  logic        is_bc;
  logic        is_io;
  logic        io_set;
  logic        nv;
  logic [11:0] tgt;
  logic [8:0]  rol_e;
  logic [7:0]  asr_e;
  logic [7:0]  bst_e;
  assign take   = INSTR.valid && INSTR_READY;
  assign is_bc  = INSTR.op == bbou_pkg::OP_BRANCH_FLAG_CLEAR;
  assign io_set = INSTR.op == bbou_pkg::OP_IO_BIT_SET;
  assign is_io  = io_set || INSTR.op == bbou_pkg::OP_IO_BIT_CLEAR;
  assign nv     = FLAGS[2] ^ FLAGS[3];
  assign tgt    = INSTR.pc + {{5{INSTR.offset[6]}}, INSTR.offset} + 12'h001;
  assign rol_e  = {INSTR.rd_val, FLAGS[0]};
  assign asr_e  = {INSTR.rd_val[7], INSTR.rd_val[7:1]};
  assign bst_e  = {FLAGS[7], INSTR.rr_val[INSTR.bit_sel], FLAGS[5:0]};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_done; take |=> RESULT.done; endproperty
  property p_bc_t;
    take && is_bc && !FLAGS[INSTR.bit_sel] |=>
      RESULT.pc_load && RESULT.pc_value == $past(tgt) && !INSTR_READY ##1 INSTR_READY;
  endproperty
  property p_bc_n;
    take && is_bc && FLAGS[INSTR.bit_sel] |=> !RESULT.pc_load && INSTR_READY;
  endproperty
  property p_ge;
    take && INSTR.op == bbou_pkg::OP_BRANCH_SIGNED_GE |=> RESULT.pc_load == !$past(nv);
  endproperty
  property p_lt;
    take && INSTR.op == bbou_pkg::OP_BRANCH_SIGNED_LT |=> RESULT.pc_load == $past(nv);
  endproperty
  property p_io;
    take && is_io |=> RESULT.io_we && RESULT.io_val == $past(io_set)
      && RESULT.io_bit == $past(INSTR.bit_sel) && $stable(FLAGS) && !INSTR_READY;
  endproperty
  property p_rol;
    take && INSTR.op == bbou_pkg::OP_ROTATE_LEFT_CARRY
      |=> {FLAGS[0], RESULT.rd_data} == $past(rol_e);
  endproperty
  property p_asr;
    take && INSTR.op == bbou_pkg::OP_ARITH_SHIFT_RIGHT |=> RESULT.rd_data == $past(asr_e);
  endproperty
  property p_bst;
    take && INSTR.op == bbou_pkg::OP_STORE_BIT_TO_T |=> FLAGS == $past(bst_e);
  endproperty
  property p_rdy; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  property p_err; PSLVERR |-> PREADY; endproperty
  a_done: assert property (p_done)
    else $error("no done after take");
  a_bc_t: assert property (p_bc_t)
    else $error("taken branch wrong");
  a_bc_n: assert property (p_bc_n)
    else $error("untaken branch wrong");
  a_ge: assert property (p_ge)
    else $error("signed ge wrong");
  a_lt: assert property (p_lt)
    else $error("signed lt wrong");
  a_io: assert property (p_io)
    else $error("io bit op wrong");
  a_rol: assert property (p_rol)
    else $error("rotate left wrong");
  a_asr: assert property (p_asr)
    else $error("arith shift wrong");
  a_bst: assert property (p_bst)
    else $error("bit store wrong");
  a_rdy: assert property (p_rdy)
    else $error("apb ready late");
  a_err: assert property (p_err)
    else $error("error without ready");
  c_taken: cover property (take && is_bc && !FLAGS[INSTR.bit_sel]);
  c_io: cover property (take && is_io);
  c_err: cover property (PSLVERR);
endmodule
bind bbou_unit bbou_sva u_sva (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .INSTR(INSTR), .INSTR_READY(INSTR_READY), .RESULT(RESULT), .FLAGS(FLAGS));
`default_nettype wire

// [verif/bbou_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// I/O space and register file behind the unit.
// ----------------------------------------------------------------
module bbou_far_side (
  // Clock and reset.
  input wire logic                      clk,
  input wire logic                      rst_n,
  // Results from the unit.
  input wire bbou_pkg::bbou_result_type result,
  // Peek port.
  input wire logic [4:0]                peek_addr,
  output logic [7:0]                    peek_io,
  output logic [7:0]                    peek_reg
);
  logic [7:0] io_mem [32];
  logic [7:0] reg_file [32];
  assign peek_io  = io_mem[peek_addr];
  assign peek_reg = reg_file[peek_addr];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        io_mem[i]   <= 8'h00;
        reg_file[i] <= 8'h00;
      end
    end else begin
      if (result.io_we) begin
        io_mem[result.io_addr][result.io_bit] <= result.io_val;
      end
      if (result.rd_we) begin
        reg_file[result.rd_addr] <= result.rd_data;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/test_bbou_unit.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Testbench.
// ----------------------------------------------------------------
module test_bbou_unit;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, instr_ready, err;
  logic [7:0] paddr, flags, pio, preg;
  logic [31:0] pwdata, prdata, rd;
  bbou_pkg::bbou_instr_type instr;
  bbou_pkg::bbou_result_type res, got;
  int fails, checks_done, cyc;
  bbou_unit dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .INSTR(instr), .INSTR_READY(instr_ready), .RESULT(res), .FLAGS(flags));
  bbou_far_side u_far (.clk(clk), .rst_n(rst_n), .result(res), .peek_addr(5'h1F),
    .peek_io(pio), .peek_reg(preg));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input int op, input logic [7:0] rv, rr,
                     input logic [2:0] b, input logic [6:0] k);
    @(posedge clk);
    instr <= '{1'b1, bbou_pkg::bbou_op_type'(op), 5'h1F, rv, rr, b, 5'h1F, k, 12'h010};
    do @(negedge clk); while (instr_ready !== 1'b1);
    @(posedge clk);
    instr.valid <= 1'b0;
    @(negedge clk);
    got = res;
  endtask
  function automatic logic taken(input int op, input logic [7:0] f, input logic [2:0] s);
    case (op)
      1: return !f[s];
      2: return f[1];
      3: return !f[1];
      4, 7: return f[0];
      5, 6: return !f[0];
      8: return f[2];
      9: return !f[2];
      10: return !(f[2] ^ f[3]);
      11: return f[2] ^ f[3];
      12: return f[5];
      13: return !f[5];
      14: return f[6];
      15: return !f[6];
      16: return f[3];
      17: return !f[3];
      18: return f[7];
      default: return !f[7];
    endcase
  endfunction
  task automatic s_regs();
    logic [31:0] r0;
    chk("ready", 1, instr_ready);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 0);
      chk("reg reset", i == 1, rd);
    end
    apb(1'b0, 8'h10, 0);
    chk("unmapped err", 1, err);
    apb(1'b1, 8'h08, 32'hFFFFFFFF);
    apb(1'b0, 8'h08, 0);
    chk("status ro", 0, rd);
    apb(1'b1, 8'h04, 0);
    @(negedge clk);
    chk("hold ready", 0, instr_ready);
    apb(1'b1, 8'h04, 1);
    apb(1'b0, 8'h0C, 0);
    r0 = rd;
    for (int i = 0; i < 3; i++) run(0, 0, 0, 0, 0);
    apb(1'b0, 8'h0C, 0);
    chk("retired", r0 + 3, rd);
  endtask
  task automatic s_branch();
    logic [7:0] fv [4] = '{8'h00, 8'hFF, 8'h04, 8'h28};
    logic [6:0] k;
    logic t;
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, 8'h00, {24'h0, fv[f]});
      for (int i = 1; i < 20; i++) begin
        k = i[0] ? 7'h40 : 7'h3F;
        run(i, 0, 0, i[2:0], k);
        t = taken(i, fv[f], i[2:0]);
        chk("done", 1, got.done);
        chk("pc_load", t, got.pc_load);
        if (t) chk("pc_value", 12'h011 + {{5{k[6]}}, k}, got.pc_value);
        chk("branch flags", fv[f], flags);
      end
    end
    apb(1'b0, 8'h08, 0);
    chk("status taken", 32'h00000002, rd);
  endtask
  task automatic s_shift();
    logic [7:0] vs [4] = '{8'h96, 8'h01, 8'h80, 8'h00};
    logic [7:0] fl, r, ef;
    logic c;
    foreach (vs[j]) begin
      for (int op = 22; op < 28; op++) begin
        fl = {4'h3, 3'h0, vs[j][4]};
        apb(1'b1, 8'h00, {24'h0, fl});
        run(op, vs[j], 0, 0, 0);
        case (op)
          22: {c, r} = {vs[j], 1'b0};
          23: {r, c} = {1'b0, vs[j]};
          24: {c, r} = {vs[j], fl[0]};
          25: {r, c} = {fl[0], vs[j]};
          26: {r, c} = {vs[j][7], vs[j]};
          default: {c, r} = {fl[0], vs[j][3:0], vs[j][7:4]};
        endcase
        ef = (op == 27) ? fl : {fl[7:4], r[7] ^ c, r[7], r == 8'h00, c};
        chk("rd_data", r, got.rd_data);
        chk("shift flags", ef, flags);
        chk("rd_we", 1, got.rd_we);
      end
    end
  endtask
  task automatic s_flagops();
    logic [2:0] fb [7] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h4, 3'h3, 3'h6};
    logic [7:0] ef;
    ef = 8'h5A;
    apb(1'b1, 8'h00, {24'h0, ef});
    for (int i = 32; i < 46; i++) begin
      run(i, 0, 0, 0, 0);
      ef[fb[(i - 32) / 2]] = (i % 2 == 0);
      chk("flag op", ef, flags);
    end
    for (int i = 0; i < 16; i++) begin
      run(28 + i[0], 0, 0, i[3:1], 0);
      ef[i[3:1]] = !i[0];
      chk("indexed flag", ef, flags);
    end
  endtask
  task automatic s_bits();
    logic [7:0] e;
    logic [7:0] rr_pat = 8'hA5;
    logic [9:0] io_seen;
    apb(1'b1, 8'h00, 0);
    for (int b = 0; b < 8; b++) begin
      run(30, 0, rr_pat, b, 0);
      chk("store t", {1'b0, rr_pat[b], 6'h00}, flags);
      run(31, 8'h0F, 0, b, 0);
      e = 8'h0F;
      e[b] = rr_pat[b];
      chk("load t", e, got.rd_data);
    end
    @(negedge clk);
    chk("reg file", e, preg);
    for (int i = 0; i < 16; i++) begin
      run(20 + (i / 8), 0, 0, i[2:0], 0);
      chk("stall", 0, instr_ready);
      io_seen = {got.io_we, got.io_addr, got.io_bit, got.io_val};
      chk("io req", {1'b1, 5'h1F, i[2:0], i < 8}, io_seen);
      @(negedge clk);
      if (i == 7) chk("io set", 8'hFF, pio);
    end
    chk("io clear", 8'h00, pio);
  endtask
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    instr = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_branch();
    s_shift();
    s_flagops();
    s_bits();
    finish_test();
  end
endmodule
`default_nettype wire
